/* design/tap_defs.vh */
`ifndef TAP_DEFS_VH
`define TAP_DEFS_VH

// ************************************************************
// Scan chain geometry
// ************************************************************
`define IR_LEN 3
// Smallest variant; other variants use 417, 465 or 645 cells
`define BSR_LEN 273
`define SNOOP_WIDTH 8
`define SNOOP_DEPTH 16
`define SNOOP_AW 4
`define SNOOP_CNT_W 3
`define SNOOP_LAST 3'h7

// ************************************************************
// Instruction codes and capture pattern
// ************************************************************
`define OP_EXTEST 3'h0
`define OP_SAMPLE 3'h5
`define OP_BYPASS 3'h7
`define IR_CAPTURE 3'h1

// ************************************************************
// Data register selection
// ************************************************************
`define SEL_BYPASS 1'h0
`define SEL_BOUNDARY 1'h1

`endif

/* design/snoop_fifo.v */
`timescale 1ns/1ps

module snoop_fifo
#(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW = 4
)
(
   input wire clk_in,
   input wire sys_rst_in,
   input wire ce_in,
   input wire in_valid_in,
   output wire in_ready_out,
   input wire [WIDTH-1:0] in_data_in,
   output reg out_valid_out,
   input wire out_ready_in,
   output reg [WIDTH-1:0] out_data_out
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;

   // Count covers the array only; output register is an extra slot
   assign in_ready_out = (count != DEPTH[AW:0]);
   assign push = in_valid_in && in_ready_out;
   assign pop = (count != {(AW+1){1'b0}}) && (!out_valid_out || out_ready_in);

   // ************************************************************
   // Storage and pointers
   // ************************************************************
   always @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
         out_valid_out <= 1'b0;
         out_data_out <= {WIDTH{1'b0}};
      end
      else if (ce_in)
      begin
         if (push)
         begin
            mem[wr_ptr] <= in_data_in;
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop)
         begin
            out_data_out <= mem[rd_ptr];
            rd_ptr <= rd_ptr + 1'b1;
            out_valid_out <= 1'b1;
         end
         else if (out_ready_in)
            out_valid_out <= 1'b0;
         count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end

endmodule // snoop_fifo

/* design/scan_tap.v */
// Operation
// R1 - Sample/preload captures the pin states without disturbing the core and loads a pattern.
// R2 - Extest drives the pins from the boundary register and captures the input pins.
// R3 - Bypass puts a one-bit register between data in and data out, core running normally.
// R4 - The instruction register is three bits and each instruction scan shifts three bits.
// R5 - The boundary register holds a fixed variant-dependent number of cells, shifted whole.
// R6 - Test port inputs are weakly pulled up so an undriven input reads high.
// R7 - The port follows the sixteen-state TMS machine; all-ones and unknown codes select bypass.
`timescale 1ns/1ps
`include "tap_defs.vh"

module scan_tap
(
   input wire clk_in,
   input wire sys_rst_in,
   input wire ce_in,
   input wire tck_in,
   input wire tms_in,
   input wire tdi_in,
   output reg tdo_out,
   output reg tdo_oe_n_out,
   input wire [`BSR_LEN-1:0] core_out_in,
   input wire [`BSR_LEN-1:0] pin_in,
   output reg [`BSR_LEN-1:0] pin_out,
   output reg [`BSR_LEN-1:0] core_in_out,
   output wire test_mode_out,
   output wire [`SNOOP_WIDTH-1:0] scan_data_out,
   output wire scan_valid_out,
   input wire scan_ready_in,
   output wire scan_fill_ready_out,
   output reg scan_overflow_out
);

   // ************************************************************
   // TAP state codes
   // ************************************************************
   localparam [3:0] TLR = 4'h0;
   localparam [3:0] RTI = 4'h1;
   localparam [3:0] SEL_DR = 4'h2;
   localparam [3:0] CAP_DR = 4'h3;
   localparam [3:0] SH_DR = 4'h4;
   localparam [3:0] EX1_DR = 4'h5;
   localparam [3:0] PA_DR = 4'h6;
   localparam [3:0] EX2_DR = 4'h7;
   localparam [3:0] UPD_DR = 4'h8;
   localparam [3:0] SEL_IR = 4'h9;
   localparam [3:0] CAP_IR = 4'hA;
   localparam [3:0] SH_IR = 4'hB;
   localparam [3:0] EX1_IR = 4'hC;
   localparam [3:0] PA_IR = 4'hD;
   localparam [3:0] EX2_IR = 4'hE;
   localparam [3:0] UPD_IR = 4'hF;

   reg tck_s1, tck_s2, tck_q;
   reg tms_s1, tms_s2;
   reg tdi_s1, tdi_s2;
   reg [`BSR_LEN-1:0] pin_s1, pin_s2;
   reg [3:0] state;
   reg [3:0] next_state;
   reg [`IR_LEN-1:0] ir;
   reg [`IR_LEN-1:0] ir_shift;
   reg [`BSR_LEN-1:0] bsr_shift;
   reg [`BSR_LEN-1:0] bsr_upd;
   reg bypass_bit;
   reg [`SNOOP_WIDTH-1:0] snoop_byte;
   reg [`SNOOP_CNT_W-1:0] snoop_cnt;
   reg snoop_push;
   wire tck_rise;
   wire tck_fall;
   wire fill_ready;

   // Decode of the active instruction to a data register
   function sel_of;
      input [`IR_LEN-1:0] code;
      begin
         if (code == `OP_EXTEST || code == `OP_SAMPLE)
            sel_of = `SEL_BOUNDARY;
         else
            sel_of = `SEL_BYPASS; // R7
      end
   endfunction

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   // Pads carry pull-ups, so idle TMS and TDI are taken as high; TCK stages reset low
   always @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         tck_s1 <= 1'b0;
         tck_s2 <= 1'b0;
         tck_q <= 1'b0;
         tms_s1 <= 1'b1; // R6
         tms_s2 <= 1'b1; // R6
         tdi_s1 <= 1'b1; // R6
         tdi_s2 <= 1'b1; // R6
         pin_s1 <= {`BSR_LEN{1'b0}};
         pin_s2 <= {`BSR_LEN{1'b0}};
      end
      else if (ce_in)
      begin
         tck_s1 <= tck_in;
         tck_s2 <= tck_s1;
         tck_q <= tck_s2;
         tms_s1 <= tms_in;
         tms_s2 <= tms_s1;
         tdi_s1 <= tdi_in;
         tdi_s2 <= tdi_s1;
         pin_s1 <= pin_in;
         pin_s2 <= pin_s1;
      end
   end

   // Edges seen only after both stages, never on the first
   assign tck_rise = tck_s2 && !tck_q;
   assign tck_fall = !tck_s2 && tck_q;

   // ************************************************************
   // TMS state machine
   // ************************************************************
   always @*
   begin
      case (state) // R7
         TLR: next_state = tms_s2 ? TLR : RTI;
         RTI: next_state = tms_s2 ? SEL_DR : RTI;
         SEL_DR: next_state = tms_s2 ? SEL_IR : CAP_DR;
         CAP_DR: next_state = tms_s2 ? EX1_DR : SH_DR;
         SH_DR: next_state = tms_s2 ? EX1_DR : SH_DR;
         EX1_DR: next_state = tms_s2 ? UPD_DR : PA_DR;
         PA_DR: next_state = tms_s2 ? EX2_DR : PA_DR;
         EX2_DR: next_state = tms_s2 ? UPD_DR : SH_DR;
         UPD_DR: next_state = tms_s2 ? SEL_DR : RTI;
         SEL_IR: next_state = tms_s2 ? TLR : CAP_IR;
         CAP_IR: next_state = tms_s2 ? EX1_IR : SH_IR;
         SH_IR: next_state = tms_s2 ? EX1_IR : SH_IR;
         EX1_IR: next_state = tms_s2 ? UPD_IR : PA_IR;
         PA_IR: next_state = tms_s2 ? EX2_IR : PA_IR;
         EX2_IR: next_state = tms_s2 ? UPD_IR : SH_IR;
         UPD_IR: next_state = tms_s2 ? SEL_DR : RTI;
         default: next_state = TLR;
      endcase
   end

   // ************************************************************
   // Capture and shift on the rising test clock
   // ************************************************************
   always @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         state <= TLR;
         ir_shift <= `IR_CAPTURE;
         bsr_shift <= {`BSR_LEN{1'b0}};
         bypass_bit <= 1'b0;
      end
      else if (ce_in && tck_rise)
      begin
         state <= next_state;
         case (state)
            CAP_IR: ir_shift <= `IR_CAPTURE;
            // Three-bit path, LSB leaves first
            SH_IR: ir_shift <= {tdi_s2, ir_shift[`IR_LEN-1:1]}; // R4
            CAP_DR:
            begin
               // Same capture for both: pins only, core untouched
               if (sel_of(ir) == `SEL_BOUNDARY)
                  bsr_shift <= pin_s2; // R1 R2
               else
                  bypass_bit <= 1'b0; // R3
            end
            SH_DR:
            begin
               if (sel_of(ir) == `SEL_BOUNDARY)
                  bsr_shift <= {tdi_s2, bsr_shift[`BSR_LEN-1:1]}; // R5
               else
                  bypass_bit <= tdi_s2; // R3
            end
            default: bypass_bit <= bypass_bit;
         endcase
      end
   end

   // ************************************************************
   // Update and data out on the falling test clock
   // ************************************************************
   always @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         ir <= `OP_BYPASS;
         bsr_upd <= {`BSR_LEN{1'b0}};
         tdo_out <= 1'b1;
         tdo_oe_n_out <= 1'b1;
      end
      else if (ce_in && tck_fall)
      begin
         // Out is enabled only while a shift state is held
         tdo_oe_n_out <= !(state == SH_IR || state == SH_DR);
         if (state == SH_IR)
            tdo_out <= ir_shift[0];
         else if (sel_of(ir) == `SEL_BOUNDARY)
            tdo_out <= bsr_shift[0];
         else
            tdo_out <= bypass_bit; // R3
         case (state)
            TLR: ir <= `OP_BYPASS; // R7
            UPD_IR: ir <= ir_shift; // R4
            // Preload for sample, drive pattern for extest
            UPD_DR:
            begin
               if (sel_of(ir) == `SEL_BOUNDARY)
                  bsr_upd <= bsr_shift; // R1 R2
            end
            default: ir <= ir;
         endcase
      end
   end

   assign test_mode_out = (ir == `OP_EXTEST);

   // ************************************************************
   // Pin and core paths
   // ************************************************************
   // Only extest takes the pins away from the core
   always @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         pin_out <= {`BSR_LEN{1'b0}};
         core_in_out <= {`BSR_LEN{1'b0}};
      end
      else if (ce_in)
      begin
         pin_out <= test_mode_out ? bsr_upd : core_out_in; // R2 R1 R3
         core_in_out <= pin_s2;
      end
   end

   // ************************************************************
   // Shift data snoop into the stream buffer
   // ************************************************************
   // Test clock cannot be held, so a full buffer drops bytes and flags it
   always @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         snoop_byte <= {`SNOOP_WIDTH{1'b0}};
         snoop_cnt <= {`SNOOP_CNT_W{1'b0}};
         snoop_push <= 1'b0;
         scan_overflow_out <= 1'b0;
      end
      else if (ce_in)
      begin
         snoop_push <= 1'b0;
         if (snoop_push && !fill_ready)
            scan_overflow_out <= 1'b1;
         if (tck_rise && state == SH_DR)
         begin
            snoop_byte <= {tdi_s2, snoop_byte[`SNOOP_WIDTH-1:1]};
            snoop_cnt <= snoop_cnt + 1'b1;
            if (snoop_cnt == `SNOOP_LAST)
               snoop_push <= 1'b1;
         end
         else if (tck_rise && state == CAP_DR)
            snoop_cnt <= {`SNOOP_CNT_W{1'b0}};
      end
   end

   assign scan_fill_ready_out = fill_ready;

   snoop_fifo #(
      .WIDTH(`SNOOP_WIDTH),
      .DEPTH(`SNOOP_DEPTH),
      .AW(`SNOOP_AW)
   ) u_fifo (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .ce_in(ce_in),
      .in_valid_in(snoop_push),
      .in_ready_out(fill_ready),
      .in_data_in(snoop_byte),
      .out_valid_out(scan_valid_out),
      .out_ready_in(scan_ready_in),
      .out_data_out(scan_data_out)
   );

endmodule // scan_tap

/* verification/tap_ctl.sv */
`timescale 1ns/1ps
// ****
// Test controller model
// ****
module tap_ctl
(
   input wire clk_in,
   input wire tdo_in,
   output logic tck_out,
   output logic tms_out,
   output logic tdi_out
);
   // Clock rests low between frames
   initial
   begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b1;
   end
   // One TCK period of eight clocks; TMS and TDI move with the fall, TDO is taken at the rise
   task tbit(input logic m, input logic d, output logic q);
   begin
      tms_out = m;
      tdi_out = d;
      repeat (4) @(negedge clk_in);
      tck_out = 1'b1;
      q = tdo_in;
      repeat (4) @(negedge clk_in);
      tck_out = 1'b0;
   end
   endtask
   // Five ones always reach reset, then idle
   task reset_tap;
      logic q;
   begin
      repeat (5) tbit(1'b1, 1'b1, q);
      tbit(1'b0, 1'b1, q);
   end
   endtask
   // Idle to idle; last bit leaves shift
   task scan(input logic ir, input int n, input logic [272:0] din, output logic [272:0] dout);
      logic q;
   begin
      dout = '0;
      tbit(1'b1, 1'b1, q);
      if (ir)
         tbit(1'b1, 1'b1, q);
      tbit(1'b0, 1'b1, q);
      tbit(1'b0, 1'b1, q);
      for (int i = 0; i < n; i++)
      begin
         tbit(i == n - 1, din[i], q);
         dout[i] = q;
      end
      tbit(1'b1, 1'b1, q);
      tbit(1'b0, 1'b1, q);
   end
   endtask
endmodule // tap_ctl

/* verification/scan_tap_asserts.sv */
`timescale 1ns/1ps
`include "tap_defs.vh"
// ****
// Port checks
// ****
module scan_tap_asserts
(
   input wire clk_in,
   input wire sys_rst_in,
   input wire ce_in,
   input wire tck_in,
   input wire tdo_out,
   input wire tdo_oe_n_out,
   input wire [`BSR_LEN-1:0] core_out_in,
   input wire [`BSR_LEN-1:0] pin_in,
   input wire [`BSR_LEN-1:0] pin_out,
   input wire [`BSR_LEN-1:0] core_in_out,
   input wire test_mode_out,
   input wire [`SNOOP_WIDTH-1:0] scan_data_out,
   input wire scan_valid_out,
   input wire scan_ready_in,
   input wire scan_fill_ready_out,
   input wire scan_overflow_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   property p_pin_norm;
      ce_in && !test_mode_out |=> pin_out == $past(core_out_in);
   endproperty
   a_pin_norm: assert property (p_pin_norm) else $error("pin_out not core");
   // Chain delay is fixed, so the pad path stays transparent
   property p_core_in;
      !$past(sys_rst_in, 3) && $past(ce_in) && $past(ce_in, 2) && $past(ce_in, 3)
         |-> core_in_out == $past(pin_in, 3);
   endproperty
   a_core_in: assert property (p_core_in) else $error("core_in_out lag");
   property p_pin_hold;
      (test_mode_out && $stable(tck_in)) [*8] |-> $stable(pin_out);
   endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("pin_out moved");
   property p_mode_fall;
      $changed(test_mode_out) |-> !tck_in;
   endproperty
   a_mode_fall: assert property (p_mode_fall) else $error("mode off fall");
   property p_tdo_fall;
      $changed(tdo_out) |-> !tck_in && !$past(tck_in);
   endproperty
   a_tdo_fall: assert property (p_tdo_fall) else $error("tdo off fall");
   property p_oe_fall;
      $changed(tdo_oe_n_out) |-> !tck_in && !$past(tck_in);
   endproperty
   a_oe_fall: assert property (p_oe_fall) else $error("oe off fall");
   property p_rst_state;
      $fell(sys_rst_in) |-> tdo_oe_n_out && tdo_out && !test_mode_out && !scan_valid_out;
   endproperty
   a_rst_state: assert property (p_rst_state) else $error("bad reset state");
   property p_valid_hold;
      scan_valid_out && !scan_ready_in |=> scan_valid_out && $stable(scan_data_out);
   endproperty
   a_valid_hold: assert property (p_valid_hold) else $error("byte not held");
   property p_ovf_cause;
      $rose(scan_overflow_out) |-> !$past(scan_fill_ready_out);
   endproperty
   a_ovf_cause: assert property (p_ovf_cause) else $error("overflow not full");
   c_ovf: cover property ($rose(scan_overflow_out));
   c_ext: cover property (test_mode_out);
   c_take: cover property (scan_valid_out && scan_ready_in);
endmodule // scan_tap_asserts
bind scan_tap scan_tap_asserts scan_tap_asserts_inst
(
   .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in), .tck_in(tck_in),
   .tdo_out(tdo_out), .tdo_oe_n_out(tdo_oe_n_out), .core_out_in(core_out_in),
   .pin_in(pin_in), .pin_out(pin_out), .core_in_out(core_in_out),
   .test_mode_out(test_mode_out), .scan_data_out(scan_data_out),
   .scan_valid_out(scan_valid_out), .scan_ready_in(scan_ready_in),
   .scan_fill_ready_out(scan_fill_ready_out), .scan_overflow_out(scan_overflow_out)
);

/* verification/scan_tap_tb.sv */
`timescale 1ns/1ps
`include "tap_defs.vh"
// ****
// Bench
// ****
module scan_tap_tb;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic ce_in = 1'b1;
   logic scan_ready_in = 1'b1;
   logic [`BSR_LEN-1:0] core_out_in = '0;
   logic [`BSR_LEN-1:0] pin_in = '0;
   wire tck, tms, tdi, tdo_out, tdo_oe_n_out, test_mode_out, scan_valid_out;
   wire scan_fill_ready_out, scan_overflow_out;
   wire tdo_line;
   wire [`BSR_LEN-1:0] pin_out, core_in_out;
   wire [`SNOOP_WIDTH-1:0] scan_data_out;
   logic [272:0] d, q;
   int mismatches = 0;
   int cmp_count = 0;
   int cyc = 0;
   always #20 clk_in = ~clk_in;
   // Released TDO floats to the pad pull-up, so a late enable shows as ones
   assign tdo_line = tdo_oe_n_out ? 1'b1 : tdo_out;
   scan_tap scan_tap_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
      .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo_out),
      .tdo_oe_n_out(tdo_oe_n_out), .core_out_in(core_out_in), .pin_in(pin_in),
      .pin_out(pin_out), .core_in_out(core_in_out), .test_mode_out(test_mode_out),
      .scan_data_out(scan_data_out), .scan_valid_out(scan_valid_out),
      .scan_ready_in(scan_ready_in), .scan_fill_ready_out(scan_fill_ready_out),
      .scan_overflow_out(scan_overflow_out));
   tap_ctl tap_ctl_inst (.clk_in(clk_in), .tdo_in(tdo_line), .tck_out(tck), .tms_out(tms),
      .tdi_out(tdi));
   task chk(input string nm, input logic [272:0] seen, input logic [272:0] exp);
   begin
      cmp_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   end
   endtask
   task give_verdict;
   begin
      if (mismatches == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   // Hang guard, well above the few thousand cycles needed
   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         mismatches++;
         give_verdict;
      end
   end
   task load_ir(input logic [2:0] c);
   begin
      tap_ctl_inst.scan(1'b1, `IR_LEN, 273'(c), q);
      chk("ir_cap", q[2:0], `IR_CAPTURE);
   end
   endtask
   task t_bypass(input logic [2:0] c);
   begin
      core_out_in = {91{c}};
      load_ir(c);
      chk("mode", test_mode_out, 1'b0);
      tap_ctl_inst.scan(1'b0, 8, 273'hA5, q);
      chk("bypass", q[7:0], 8'h4A);
      chk("pins", pin_out, core_out_in);
   end
   endtask
   task t_sample;
   begin
      pin_in = {91{3'h5}};
      core_out_in = {91{3'h6}};
      load_ir(`OP_SAMPLE);
      tap_ctl_inst.scan(1'b0, `BSR_LEN, {91{3'h3}}, q);
      chk("capture", q, pin_in);
      chk("pins", pin_out, core_out_in);
      chk("core", core_in_out, pin_in);
   end
   endtask
   task t_extest;
   begin
      load_ir(`OP_EXTEST);
      repeat (8) @(negedge clk_in);
      chk("mode", test_mode_out, 1'b1);
      chk("preload", pin_out, {91{3'h3}});
      tap_ctl_inst.scan(1'b0, `BSR_LEN, {91{3'h4}}, q);
      chk("ext_cap", q, pin_in);
      repeat (8) @(negedge clk_in);
      chk("drive", pin_out, {91{3'h4}});
      load_ir(`OP_BYPASS);
      chk("mode", test_mode_out, 1'b0);
   end
   endtask
   // Sink stalls; sixteen stored plus the output register, so the eighteenth byte is lost
   task t_fifo;
   begin
      scan_ready_in = 1'b0;
      d = '0;
      for (int i = 0; i < 18; i++)
         d[8*i +: 8] = 8'(i);
      tap_ctl_inst.scan(1'b0, 144, d, q);
      chk("full", scan_fill_ready_out, 1'b0);
      chk("ovf", scan_overflow_out, 1'b1);
      scan_ready_in = 1'b1;
      for (int i = 0; i < 17; i++)
      begin
         while (scan_valid_out !== 1'b1)
            @(negedge clk_in);
         chk("byte", scan_data_out, 8'(i));
         @(negedge clk_in);
      end
      chk("empty", scan_valid_out, 1'b0);
   end
   endtask
   // Enable low must freeze the pad and pin paths, then they resume
   task t_freeze;
   begin
      ce_in = 1'b0;
      pin_in = {91{3'h2}};
      core_out_in = {91{3'h1}};
      repeat (8) @(negedge clk_in);
      chk("hold_pin", pin_out, {91{3'h6}});
      chk("hold_core", core_in_out, {91{3'h5}});
      ce_in = 1'b1;
      repeat (4) @(negedge clk_in);
      chk("run_pin", pin_out, core_out_in);
      chk("run_core", core_in_out, pin_in);
   end
   endtask
   initial
   begin
      repeat (12) @(negedge clk_in);
      sys_rst_in = 1'b0;
      repeat (4) @(negedge clk_in);
      chk("oe_n", tdo_oe_n_out, 1'b1);
      tap_ctl_inst.reset_tap;
      t_bypass(`OP_BYPASS);
      t_bypass(3'h3);
      t_sample;
      t_extest;
      t_fifo;
      t_freeze;
      give_verdict;
   end
endmodule // scan_tap_tb
